// File: logic/nvc_pkg.sv
// package: register map, field layout and timing of the nv access controller
package nvc_pkg;

  // ------------------------------------------------------------
  // register offsets (i/o space)
  // ------------------------------------------------------------
  localparam logic [7:0] NVC_OFS_ADDR_LO = 8'h21;
  localparam logic [7:0] NVC_OFS_ADDR_HI = 8'h22;
  localparam logic [7:0] NVC_OFS_DATA    = 8'h20;
  localparam logic [7:0] NVC_OFS_CTRL    = 8'h1f;

  // ------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------
  localparam int NVC_BIT_READ   = 0;
  localparam int NVC_BIT_WRITE  = 1;
  localparam int NVC_BIT_MASTER = 2;
  localparam int NVC_BIT_RIE    = 3;
  localparam int NVC_BIT_PM_LO  = 4;
  localparam int NVC_BIT_PM_HI  = 5;

  localparam logic [1:0] NVC_PM_RESET = 2'h0;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam logic [2:0]  NVC_MASTER_CYCLES   = 3'h4;
  localparam logic [2:0]  NVC_WR_STALL_CYCLES = 3'h2;
  localparam logic [2:0]  NVC_RD_STALL_CYCLES = 3'h4;
  localparam int          NVC_PROG_RC_CYCLES  = 26368;
  localparam int          NVC_PROG_TIME_US    = 3300;
  localparam int          NVC_CLK_MHZ         = 100;
  localparam int          NVC_ADDR_W          = 9;
  localparam int          NVC_DEPTH           = 512;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    NVC_PM_ATOMIC = 2'b00,
    NVC_PM_ERASE  = 2'b01,
    NVC_PM_WRITE  = 2'b10,
    NVC_PM_RSVD   = 2'b11
  } nvc_mode_t;

  typedef enum logic [1:0] {
    NVC_ST_IDLE = 2'b00,
    NVC_ST_PROG = 2'b01
  } nvc_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } nvc_io_t;

endpackage : nvc_pkg

// File: logic/nvc_rc_tick.sv
// rc oscillator stand-in: one-cycle tick divider
`timescale 1ns/1ps
module nvc_rc_tick
  import nvc_pkg::*;
#(
  parameter int DIV = 12
) (
  input  wire logic ref_clk_in,
  input  wire logic rst_b_in,
  output logic      tick_out
);

  logic [7:0] cnt_r;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_r    <= 8'h00;
      tick_out <= 1'b0;
    end else if (cnt_r == 8'(DIV - 1)) begin
      cnt_r    <= 8'h00;
      tick_out <= 1'b1;
    end else begin
      cnt_r    <= cnt_r + 8'h01;
      tick_out <= 1'b0;
    end
  end

endmodule : nvc_rc_tick

// File: logic/nvc_ctrl.sv
// nv byte access controller: address, data, control registers and array
//
// Contract
// [RULE1] bytes addressed 0..top; unused address-high bits read zero
// [RULE2] software writes zero to address bit 8 on the small variant
// [RULE3] address undefined after reset; software loads it before use
// [RULE4] data register supplies write byte; holds read byte after read
// [RULE5] control bits 7..6 read zero
// [RULE6] mode 00 erase+write, 01 erase, 10 write; 11 reserved
// [RULE7] mode writes ignored while write strobe set
// [RULE8] reset clears mode unless programming in progress
// [RULE9] ready irq held while enable, global enable, strobe clear
// [RULE10] no ready irq during write or self-programming
// [RULE11] master enable self-clears four cycles after set
// [RULE12] strobe within four cycles of master starts write, else nothing
// [RULE13] software follows the documented write sequence
// [RULE14] no programming while flash self-programming is active
// [RULE15] strobe clears at write end; setting it stalls cpu two cycles
// [RULE16] read strobe fetches byte at once; cpu stalled four cycles
// [RULE17] no read and no address change while write in progress
// [RULE18] write time counted in 26368 rc oscillator cycles
// [RULE19] software keeps interrupts off during the write sequence
// [RULE20] write in progress completes through a reset
`timescale 1ns/1ps
module nvc_ctrl
  import nvc_pkg::*;
#(
  parameter int PROG_CYCLES = NVC_PROG_RC_CYCLES,
  parameter int RC_DIV      = 12,
  parameter int ADDR_W      = NVC_ADDR_W
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       io_wr_in,
  input  wire logic       io_rd_in,
  input  wire logic [7:0] io_addr_in,
  input  wire logic [7:0] io_wdata_in,
  input  wire logic       global_irq_en_in,
  input  wire logic       self_program_enable_in,
  output logic      [7:0] io_rdata_out,
  output logic            cpu_stall_out,
  output logic            ready_irq_out,
  output logic            prog_busy_out
);

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  nvc_io_t io;
  assign io = '{wr: io_wr_in, rd: io_rd_in, addr: io_addr_in,
                wdata: io_wdata_in};

  // one write strobe per register offset
  function automatic logic reg_write(input nvc_io_t    bus,
                                     input logic [7:0] ofs);
    reg_write = bus.wr && bus.addr == ofs;
  endfunction : reg_write

  logic wr_lo, wr_hi, wr_data, wr_ctrl;
  assign wr_lo   = reg_write(io, NVC_OFS_ADDR_LO);
  assign wr_hi   = reg_write(io, NVC_OFS_ADDR_HI);
  assign wr_data = reg_write(io, NVC_OFS_DATA);
  assign wr_ctrl = reg_write(io, NVC_OFS_CTRL);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [8:0]  addr_r;
  logic [7:0]  data_r;
  logic [1:0]  mode_r;
  logic        rie_r;
  logic        master_r;
  logic [2:0]  master_cnt_r;
  logic        strobe_r;
  logic [14:0] prog_cnt_r;
  logic        rst_seen_r;
  logic [2:0]  stall_cnt_r;
  nvc_state_t  state_r;
  logic [7:0]  mem_r [NVC_DEPTH];
  logic        rc_tick;

  logic start_wr, start_rd, prog_done, busy;
  assign busy      = state_r == NVC_ST_PROG;
  // strobe only counts inside the master window, never while flash busy
  assign start_wr  = wr_ctrl && io.wdata[NVC_BIT_WRITE] && master_r
                     && !busy
                     && !self_program_enable_in; // see [RULE12] [RULE14]
  assign start_rd  = wr_ctrl && io.wdata[NVC_BIT_READ] && !busy; // see [RULE17]
  assign prog_done = busy && rc_tick &&
                     prog_cnt_r == 15'(PROG_CYCLES - 1); // see [RULE18]

  function automatic logic [8:0] addr_mask(input logic [8:0] a);
    addr_mask = a & 9'((1 << ADDR_W) - 1);
  endfunction : addr_mask

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // byte left in the cell once a programming pass ends
  function automatic logic [7:0] prog_result(
    input logic [1:0] mode,
    input logic [7:0] old_byte,
    input logic [7:0] new_byte
  );
    case (mode)
      NVC_PM_ATOMIC: prog_result = new_byte;
      NVC_PM_ERASE:  prog_result = 8'hff;
      NVC_PM_WRITE:  prog_result = old_byte & new_byte;
      default:       prog_result = old_byte;
    endcase
  endfunction : prog_result

  // control register as software sees it; read strobe reads zero
  function automatic logic [7:0] ctrl_image(
    input logic [1:0] mode,
    input logic       rie,
    input logic       master,
    input logic       strobe
  );
    ctrl_image                              = 8'h00; // see [RULE5]
    ctrl_image[NVC_BIT_PM_HI:NVC_BIT_PM_LO] = mode;
    ctrl_image[NVC_BIT_RIE]                 = rie;
    ctrl_image[NVC_BIT_MASTER]              = master;
    ctrl_image[NVC_BIT_WRITE]               = strobe;
  endfunction : ctrl_image

  // rc oscillator stand-in, divided down from the system clock

  nvc_rc_tick #(.DIV(RC_DIV)) u_rc (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .tick_out   (rc_tick)
  );

  // ------------------------------------------------------------
  // address and data registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!busy) begin // see [RULE17] [RULE3]
      if (wr_lo)
        addr_r[7:0] <= io.wdata;
      if (wr_hi)
        addr_r <= addr_mask({io.wdata[0], addr_r[7:0]}); // see [RULE1]
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (start_rd)
      data_r <= mem_r[addr_mask(addr_r)]; // see [RULE16] [RULE4]
    else if (wr_data)
      data_r <= io.wdata;
  end

  // ------------------------------------------------------------
  // programming sequencer; survives reset while busy
  // ------------------------------------------------------------
  // leave idle only on an accepted strobe
  always_ff @(posedge ref_clk_in) begin
    case (state_r)
      NVC_ST_IDLE: begin
        if (start_wr)
          state_r <= NVC_ST_PROG;
      end
      NVC_ST_PROG: begin
        if (prog_done)
          state_r <= NVC_ST_IDLE; // see [RULE20]
      end
      default: state_r <= NVC_ST_IDLE;
    endcase
    if (!rst_seen_r && !busy)
      state_r <= NVC_ST_IDLE;
  end

  // rc cycles spent on the current pass
  always_ff @(posedge ref_clk_in) begin
    if (!busy)
      prog_cnt_r <= 15'h0000;
    else if (rc_tick)
      prog_cnt_r <= prog_cnt_r + 15'h0001; // see [RULE18]
  end

  // first clock after power: sequencer not yet defined
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      rst_seen_r <= 1'b0;
    else
      rst_seen_r <= 1'b1;
  end

  always_ff @(posedge ref_clk_in) begin
    if (prog_done)
      mem_r[addr_mask(addr_r)] <= prog_result(mode_r,
                                              mem_r[addr_mask(addr_r)],
                                              data_r); // see [RULE6]
  end

  // ------------------------------------------------------------
  // strobe and mode: kept through reset while programming
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in && !busy) begin
      mode_r   <= NVC_PM_RESET; // see [RULE8]
      strobe_r <= 1'b0;
    end else begin
      if (wr_ctrl && !strobe_r)
        mode_r <= io.wdata[NVC_BIT_PM_HI:NVC_BIT_PM_LO]; // see [RULE7]
      if (start_wr)
        strobe_r <= 1'b1;
      else if (prog_done)
        strobe_r <= 1'b0; // see [RULE15]
    end
  end

  // ------------------------------------------------------------
  // ready enable and master window
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rie_r <= 1'b0;
    end else if (wr_ctrl) begin
      rie_r <= io.wdata[NVC_BIT_RIE]; // see [RULE9]
    end
  end

  // opened only by a master write with the strobe bit clear
  logic master_set;
  assign master_set = wr_ctrl && io.wdata[NVC_BIT_MASTER]
                      && !io.wdata[NVC_BIT_WRITE];

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      master_r     <= 1'b0;
      master_cnt_r <= 3'h0;
    end else if (master_set) begin
      master_r     <= 1'b1;
      master_cnt_r <= NVC_MASTER_CYCLES;
    end else if (master_cnt_r != 3'h0) begin
      master_cnt_r <= master_cnt_r - 3'h1;
      if (master_cnt_r == 3'h1)
        master_r <= 1'b0; // see [RULE11]
    end
  end

  // ------------------------------------------------------------
  // cpu stall, interrupt, read data
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stall_cnt_r <= 3'h0;
    end else if (start_rd) begin
      stall_cnt_r <= NVC_RD_STALL_CYCLES - 3'h1; // see [RULE16]
    end else if (start_wr) begin
      stall_cnt_r <= NVC_WR_STALL_CYCLES - 3'h1; // see [RULE15]
    end else if (stall_cnt_r != 3'h0) begin
      stall_cnt_r <= stall_cnt_r - 3'h1;
    end
  end

  // stall stands while the counter drains
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      cpu_stall_out <= 1'b0;
    else
      cpu_stall_out <= start_rd || start_wr || stall_cnt_r != 3'h0;
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ready_irq_out <= 1'b0;
    end else begin
      ready_irq_out <= rie_r && global_irq_en_in && !strobe_r
                       && !start_wr // see [RULE9]
                       && !self_program_enable_in; // see [RULE10]
    end
  end

  // busy follows the sequencer, which keeps running through a reset
  always_ff @(posedge ref_clk_in) begin
    prog_busy_out <= busy || start_wr; // see [RULE20]
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      io_rdata_out <= 8'h00;
    end else if (io.rd) begin
      case (io.addr)
        NVC_OFS_ADDR_LO: io_rdata_out <= addr_r[7:0];
        NVC_OFS_ADDR_HI: io_rdata_out <= {7'h00, addr_r[8]}; // see [RULE1]
        NVC_OFS_DATA:    io_rdata_out <= data_r;
        NVC_OFS_CTRL:    io_rdata_out <= ctrl_image(mode_r, rie_r, master_r,
                                                    strobe_r);
        default:         io_rdata_out <= 8'h00;
      endcase
    end
  end

endmodule : nvc_ctrl

// File: tb/nvc_ctrl_assertions.sv
// checker: port-level assertions of the nv access controller
`timescale 1ns/1ps
module nvc_ctrl_chk
  import nvc_pkg::*;
#(
  parameter int PROG_CYCLES = NVC_PROG_RC_CYCLES,
  parameter int RC_DIV      = 12
) (
  input wire logic       ref_clk_in,
  input wire logic       rst_b_in,
  input wire logic       io_wr_in,
  input wire logic       io_rd_in,
  input wire logic [7:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic       global_irq_en_in,
  input wire logic       self_program_enable_in,
  input wire logic [7:0] io_rdata_out,
  input wire logic       cpu_stall_out,
  input wire logic       ready_irq_out,
  input wire logic       prog_busy_out
);
  // ------------------------------------------------------------
  // helper counters
  // ------------------------------------------------------------
  localparam int LEN = PROG_CYCLES * RC_DIV;
  logic [31:0] busy_cnt;
  logic [3:0]  mst_age;
  logic        ctl_wr;
  assign ctl_wr = io_wr_in && io_addr_in == NVC_OFS_CTRL;
  // busy length kept through reset; reset cycles not counted
  always_ff @(posedge ref_clk_in) begin
    busy_cnt <= !prog_busy_out ? 32'h0 : busy_cnt + {31'h0, rst_b_in};
  end
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      mst_age <= 4'hf;
    else if (ctl_wr && io_wdata_in[2:1] == 2'h2)
      mst_age <= 4'h0;
    else if (mst_age != 4'hf)
      mst_age <= mst_age + 4'h1;
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  ctrl_top_zero_a: assert property (
    io_rd_in && io_addr_in == NVC_OFS_CTRL |=> io_rdata_out[7:6] == 2'h0)
    else $error("control top bits not zero");
  addr_hi_zero_a: assert property (
    io_rd_in && io_addr_in == NVC_OFS_ADDR_HI |=> io_rdata_out[7:1] == 7'h0)
    else $error("address high unused bits not zero");
  irq_busy_a: assert property (
    prog_busy_out && $past(prog_busy_out) |-> !ready_irq_out)
    else $error("ready irq during programming");
  irq_gate_a: assert property (
    !global_irq_en_in |=> !ready_irq_out)
    else $error("ready irq without global enable");
  rd_stall_a: assert property (
    ctl_wr && io_wdata_in[2:0] == 3'h1 && !prog_busy_out && !cpu_stall_out
    |=> cpu_stall_out [*4] ##1 !cpu_stall_out)
    else $error("read stall not four cycles");
  wr_stall_a: assert property (
    $rose(prog_busy_out) |-> cpu_stall_out ##1 cpu_stall_out ##1 !cpu_stall_out)
    else $error("write stall not two cycles");
  prog_len_a: assert property (
    $fell(prog_busy_out) |-> busy_cnt >= LEN / 2 - 2 && busy_cnt <= LEN + 4)
    else $error("programming time out of range");
  master_win_a: assert property (
    $rose(prog_busy_out) |-> mst_age <= 4'h6)
    else $error("programming without recent master enable");
  spm_block_a: assert property (
    ctl_wr && self_program_enable_in && !prog_busy_out
    |=> !prog_busy_out [*4])
    else $error("programming during self-programming");
  rdata_hold_a: assert property (
    !io_rd_in |=> $stable(io_rdata_out))
    else $error("read data changed without read");
endmodule : nvc_ctrl_chk

bind nvc_ctrl nvc_ctrl_chk #(.PROG_CYCLES(PROG_CYCLES), .RC_DIV(RC_DIV)) i_chk (
  .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .io_wr_in(io_wr_in),
  .io_rd_in(io_rd_in), .io_addr_in(io_addr_in), .io_wdata_in(io_wdata_in),
  .global_irq_en_in(global_irq_en_in),
  .self_program_enable_in(self_program_enable_in),
  .io_rdata_out(io_rdata_out), .cpu_stall_out(cpu_stall_out),
  .ready_irq_out(ready_irq_out), .prog_busy_out(prog_busy_out));

// File: tb/test_nvc_ctrl.sv
// testbench: register-level tests of the nv access controller
`timescale 1ns/1ps
module test_nvc_ctrl
  import nvc_pkg::*;
;
  logic       clk = 1'b0, rst_b = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
  logic       gie = 1'b0, spe = 1'b0, stall, irq, busy;
  logic [7:0] io_addr = 8'h0, io_wdata = 8'h0, rdata, v;
  logic [1:0] md [3] = '{2'h1, 2'h2, 2'h0};
  logic [7:0] dt [3] = '{8'h00, 8'h0f, 8'h3c};
  logic [7:0] ex [3] = '{8'hff, 8'h0f, 8'h3c};
  int         n_errors = 0, compares = 0, cyc = 0;
  always #5 clk = ~clk;
  nvc_ctrl #(.PROG_CYCLES(20), .RC_DIV(2)) i_dut (
    .ref_clk_in(clk), .rst_b_in(rst_b), .io_wr_in(io_wr), .io_rd_in(io_rd),
    .io_addr_in(io_addr), .io_wdata_in(io_wdata), .global_irq_en_in(gie),
    .self_program_enable_in(spe), .io_rdata_out(rdata),
    .cpu_stall_out(stall), .ready_irq_out(irq), .prog_busy_out(busy));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk); io_wr = 1'b1; io_addr = a; io_wdata = d;
    @(negedge clk); io_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk); io_rd = 1'b1; io_addr = a;
    @(negedge clk); io_rd = 1'b0; d = rdata;
  endtask : rd
  task automatic idle_wait;
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk);
    chk({7'h0, busy}, 8'h00);
  endtask : idle_wait
  // master with strobe low, then strobe, both keep irq enable
  task automatic prog(input logic [1:0] m, input logic [7:0] d);
    logic g;
    g = gie;
    gie = 1'b0;
    wr(NVC_OFS_DATA, d);
    wr(NVC_OFS_CTRL, {2'h0, m, 4'hc});
    wr(NVC_OFS_CTRL, {2'h0, m, 4'ha});
    gie = g;
  endtask : prog
  task automatic fetch(output logic [7:0] d);
    wr(NVC_OFS_CTRL, 8'h09);
    chk({7'h0, stall}, 8'h01);
    repeat (5) @(negedge clk);
    chk({7'h0, stall}, 8'h00);
    rd(NVC_OFS_DATA, d);
  endtask : fetch
  task automatic finish_test;
    $display("compares %0d, n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      finish_test;
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    gie = 1'b1;
    rd(NVC_OFS_CTRL, v);
    chk(v, 8'h00);
    rd(NVC_OFS_ADDR_HI, v);
    chk(v & 8'hfe, 8'h00);
    wr(NVC_OFS_ADDR_HI, 8'h01);
    wr(NVC_OFS_ADDR_LO, 8'hff);
    rd(NVC_OFS_ADDR_HI, v);
    chk(v, 8'h01);
    prog(2'h0, 8'h5a);
    wr(NVC_OFS_ADDR_LO, 8'h00);
    wr(NVC_OFS_CTRL, 8'h38);
    rd(NVC_OFS_CTRL, v);
    chk(v & 8'h32, 8'h02);
    chk({7'h0, irq}, 8'h00);
    idle_wait;
    @(negedge clk);
    chk({7'h0, irq}, 8'h01);
    rd(NVC_OFS_ADDR_LO, v);
    chk(v, 8'hff);
    fetch(v);
    chk(v, 8'h5a);
    for (int i = 0; i < 3; i++) begin
      prog(md[i], dt[i]);
      idle_wait;
      fetch(v);
      chk(v, ex[i]);
    end
    gie = 1'b0;
    repeat (2) @(negedge clk);
    chk({7'h0, irq}, 8'h00);
    wr(NVC_OFS_CTRL, 8'h04);
    repeat (6) @(negedge clk);
    rd(NVC_OFS_CTRL, v);
    chk(v & 8'h06, 8'h00);
    wr(NVC_OFS_CTRL, 8'h02);
    repeat (4) @(negedge clk);
    chk({7'h0, busy}, 8'h00);
    spe = 1'b1;
    wr(NVC_OFS_CTRL, 8'h04);
    wr(NVC_OFS_CTRL, 8'h02);
    repeat (4) @(negedge clk);
    chk({7'h0, busy}, 8'h00);
    spe = 1'b0;
    wr(NVC_OFS_ADDR_HI, 8'h00);
    wr(NVC_OFS_ADDR_LO, 8'h07);
    prog(2'h0, 8'hc3);
    repeat (3) @(negedge clk);
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    chk({7'h0, busy}, 8'h01);
    idle_wait;
    wr(NVC_OFS_ADDR_HI, 8'h00);
    wr(NVC_OFS_ADDR_LO, 8'h07);
    fetch(v);
    chk(v, 8'hc3);
    finish_test;
  end
endmodule : test_nvc_ctrl
